// ==== core/dbio_pkg.sv ====
package dbio_pkg;
   // data path and bus widths, register count
   localparam int DW = 12;
   localparam int AW = 8;
   localparam int NREG = 8;
   // register byte addresses
   localparam logic [7:0] A_INSTR = 8'h00;
   localparam logic [7:0] A_WORD = 8'h04;
   localparam logic [7:0] A_STAT = 8'h08;
   localparam logic [7:0] A_DEVSEL = 8'h0C;
   localparam logic [7:0] A_LEVEL = 8'h10;
   localparam logic [7:0] A_EXCL = 8'h14;
   localparam logic [7:0] A_INREG = 8'h18;
   localparam logic [7:0] A_OUTREG = 8'h1C;
   // one-hot decode positions
   localparam int RI_INSTR = 0;
   localparam int RI_WORD = 1;
   localparam int RI_STAT = 2;
   localparam int RI_DEVSEL = 3;
   localparam int RI_LEVEL = 4;
   localparam int RI_EXCL = 5;
   localparam int RI_INREG = 6;
   localparam int RI_OUTREG = 7;
   // instruction word: opcode, device group digit, unit digit, function
   localparam logic [2:0] OPC_IOT = 3'h6;
   localparam logic [2:0] DEV_GROUP = 3'h5;
   localparam logic [2:0] DEV_RST = 3'h0;
   localparam logic [2:0] F_IRQ_DIS = 3'h0;
   localparam logic [2:0] F_IRQ_EN = 3'h1;
   localparam logic [2:0] F_SKIP = 3'h2;
   localparam logic [2:0] F_IN_CLR = 3'h3;
   localparam logic [2:0] F_IN_RD = 3'h4;
   localparam logic [2:0] F_OUT_CLR = 3'h5;
   localparam logic [2:0] F_OUT_SET = 3'h6;
   localparam logic [2:0] F_OUT_RD = 3'h7;
   // status bit positions
   localparam int ST_SKIP = 0;
   localparam int ST_FLAG = 1;
   localparam int ST_IEN = 2;
   localparam int ST_IRQ = 3;
   localparam int ST_HIT = 4;
   // reset values and bus response codes
   localparam logic [11:0] OUT_RST = 12'h000;
   localparam logic [11:0] LEVEL_RST = 12'h000;
   localparam logic [11:0] EXCL_RST = 12'h000;
   localparam logic [11:0] WORD_RST = 12'h000;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // timing
   localparam longint CLK_HZ = 20000000;
   localparam longint EDGE_HOLD_NS = 50;
   localparam longint HOLD_RAW = (EDGE_HOLD_NS * CLK_HZ + 999999999) / 1000000000;
   localparam int EDGE_HOLD_CYC = (HOLD_RAW < 1) ? 1 : int'(HOLD_RAW);
endpackage

// ==== core/dbio_in_sync.sv ====
`timescale 1ns/100ps
module dbio_in_sync (
   // clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // raw lines, low means one
   input wire logic [dbio_pkg::DW-1:0] line_n,
   // conditioned view
   output logic [dbio_pkg::DW-1:0] live_ff,
   output logic [dbio_pkg::DW-1:0] fall_ff
);
   logic [dbio_pkg::DW-1:0] s1_ff, s2_ff, s3_ff;
   logic [dbio_pkg::DW-1:0] nxt_live, nxt_fall, agree;

   // a change counts only once stages two and three agree, so a low pulse
   // must cover two samples; a single-sample glitch is dropped on purpose
   always_comb begin
      agree = ~(s2_ff ^ s3_ff);
      nxt_live = (agree & ~s3_ff) | (~agree & live_ff);
      nxt_fall = agree & ~s3_ff & ~live_ff;
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         s1_ff <= 12'hFFF;
         s2_ff <= 12'hFFF;
         s3_ff <= 12'hFFF;
         live_ff <= 12'h000;
         fall_ff <= 12'h000;
      end else begin
         s1_ff <= line_n;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         live_ff <= nxt_live;
         fall_ff <= nxt_fall;
      end
   end
endmodule

// ==== core/dbio_top.sv ====
// Local design decisions: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module dbio_top (
   // clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // axi4-lite write address
   input wire logic [dbio_pkg::AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read address
   input wire logic [dbio_pkg::AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // axi4-lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // field lines, low means one
   input wire logic [dbio_pkg::DW-1:0] din_n,
   output logic [dbio_pkg::DW-1:0] dout_n,
   // interrupt request to the processor
   output logic irq_req
);
   typedef enum logic [2:0] {WS_IDLE, WS_GOT_A, WS_GOT_D, WS_EXEC, WS_RESP} dbio_wst_e;

   function automatic logic [dbio_pkg::NREG-1:0] reg_dec(input logic [dbio_pkg::AW-1:0] a);
      logic [dbio_pkg::NREG-1:0] d;
      d = '0;
      case (a)
         dbio_pkg::A_INSTR: d[dbio_pkg::RI_INSTR] = 1'b1;
         dbio_pkg::A_WORD: d[dbio_pkg::RI_WORD] = 1'b1;
         dbio_pkg::A_STAT: d[dbio_pkg::RI_STAT] = 1'b1;
         dbio_pkg::A_DEVSEL: d[dbio_pkg::RI_DEVSEL] = 1'b1;
         dbio_pkg::A_LEVEL: d[dbio_pkg::RI_LEVEL] = 1'b1;
         dbio_pkg::A_EXCL: d[dbio_pkg::RI_EXCL] = 1'b1;
         dbio_pkg::A_INREG: d[dbio_pkg::RI_INREG] = 1'b1;
         dbio_pkg::A_OUTREG: d[dbio_pkg::RI_OUTREG] = 1'b1;
         default: d = '0;
      endcase
      return d;
   endfunction

   function automatic logic [11:0] merge12(input logic [11:0] old, input logic [31:0] d,
                                           input logic [3:0] s);
      logic [11:0] r;
      r = old;
      if (s[0]) r[7:0] = d[7:0];
      if (s[1]) r[11:8] = d[11:8];
      return r;
   endfunction

   // bus state
   dbio_wst_e wst_ff, nxt_wst;
   logic [dbio_pkg::AW-1:0] waddr_ff, nxt_waddr;
   logic [31:0] wdata_ff, nxt_wdata;
   logic [3:0] wstrb_ff, nxt_wstrb;
   logic awready_ff, nxt_awready, wready_ff, nxt_wready;
   logic bvalid_ff, nxt_bvalid, arready_ff, nxt_arready, rvalid_ff, nxt_rvalid;
   logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
   logic [31:0] rdata_ff, nxt_rdata;
   logic aw_hs, w_hs, ar_hs, do_wr;
   logic [dbio_pkg::NREG-1:0] wsel, rsel;
   logic [31:0] rd_mux;

   // device state
   logic [11:0] instr_ff, nxt_instr, word_ff, nxt_word, cap_ff, nxt_cap;
   logic [11:0] dout_n_ff, nxt_dout_n, level_ff, nxt_level, excl_ff, nxt_excl;
   logic [2:0] devsel_ff, nxt_devsel;
   logic ien_ff, nxt_ien, skip_ff, nxt_skip, hit_ff, nxt_hit, irq_ff, nxt_irq;
   logic [11:0] live, fall, in_view, clr, ins;
   logic flag, exec, hit;
   logic [2:0] func;

   dbio_in_sync u_sync (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .line_n(din_n),
      .live_ff(live),
      .fall_ff(fall)
   );

   // ---------------- bus slave ----------------
   always_comb begin
      aw_hs = s_axi_awvalid & awready_ff;
      w_hs = s_axi_wvalid & wready_ff;
      ar_hs = s_axi_arvalid & arready_ff;
      wsel = reg_dec(waddr_ff);
      rsel = reg_dec(s_axi_araddr);
      do_wr = (wst_ff == WS_EXEC);
      nxt_wst = wst_ff;
      nxt_waddr = aw_hs ? s_axi_awaddr : waddr_ff;
      nxt_wdata = w_hs ? s_axi_wdata : wdata_ff;
      nxt_wstrb = w_hs ? s_axi_wstrb : wstrb_ff;
      nxt_bresp = bresp_ff;
      case (wst_ff)
         WS_IDLE: begin
            if (aw_hs && w_hs) nxt_wst = WS_EXEC;
            else if (aw_hs) nxt_wst = WS_GOT_A;
            else if (w_hs) nxt_wst = WS_GOT_D;
         end
         WS_GOT_A: if (w_hs) nxt_wst = WS_EXEC;
         WS_GOT_D: if (aw_hs) nxt_wst = WS_EXEC;
         WS_EXEC: begin
            nxt_wst = WS_RESP;
            nxt_bresp = (wsel == '0) ? dbio_pkg::RESP_SLVERR : dbio_pkg::RESP_OKAY;
         end
         WS_RESP: if (s_axi_bready) nxt_wst = WS_IDLE;
         default: nxt_wst = WS_IDLE;
      endcase
      nxt_awready = (nxt_wst == WS_IDLE) || (nxt_wst == WS_GOT_D);
      nxt_wready = (nxt_wst == WS_IDLE) || (nxt_wst == WS_GOT_A);
      nxt_bvalid = (nxt_wst == WS_RESP);

      rd_mux = '0;
      if (rsel[dbio_pkg::RI_INSTR]) rd_mux[11:0] = instr_ff;
      if (rsel[dbio_pkg::RI_WORD]) rd_mux[11:0] = word_ff;
      if (rsel[dbio_pkg::RI_STAT]) begin
         rd_mux[dbio_pkg::ST_SKIP] = skip_ff;
         rd_mux[dbio_pkg::ST_FLAG] = flag;
         rd_mux[dbio_pkg::ST_IEN] = ien_ff;
         rd_mux[dbio_pkg::ST_IRQ] = irq_ff;
         rd_mux[dbio_pkg::ST_HIT] = hit_ff;
      end
      if (rsel[dbio_pkg::RI_DEVSEL]) rd_mux[2:0] = devsel_ff;
      if (rsel[dbio_pkg::RI_LEVEL]) rd_mux[11:0] = level_ff;
      if (rsel[dbio_pkg::RI_EXCL]) rd_mux[11:0] = excl_ff;
      if (rsel[dbio_pkg::RI_INREG]) rd_mux[11:0] = in_view;
      if (rsel[dbio_pkg::RI_OUTREG]) rd_mux[11:0] = ~dout_n_ff;
      nxt_rvalid = rvalid_ff;
      nxt_rdata = rdata_ff;
      nxt_rresp = rresp_ff;
      if (ar_hs) begin
         nxt_rvalid = 1'b1;
         nxt_rdata = rd_mux;
         nxt_rresp = (rsel == '0) ? dbio_pkg::RESP_SLVERR : dbio_pkg::RESP_OKAY;
      end else if (rvalid_ff && s_axi_rready) begin
         nxt_rvalid = 1'b0;
      end
      nxt_arready = !nxt_rvalid;
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         wst_ff <= WS_IDLE;
         waddr_ff <= 8'h00;
         wdata_ff <= 32'h0000_0000;
         wstrb_ff <= 4'h0;
         awready_ff <= 1'b0;
         wready_ff <= 1'b0;
         bvalid_ff <= 1'b0;
         bresp_ff <= dbio_pkg::RESP_OKAY;
         arready_ff <= 1'b0;
         rvalid_ff <= 1'b0;
         rdata_ff <= 32'h0000_0000;
         rresp_ff <= dbio_pkg::RESP_OKAY;
      end else begin
         wst_ff <= nxt_wst;
         waddr_ff <= nxt_waddr;
         wdata_ff <= nxt_wdata;
         wstrb_ff <= nxt_wstrb;
         awready_ff <= nxt_awready;
         wready_ff <= nxt_wready;
         bvalid_ff <= nxt_bvalid;
         bresp_ff <= nxt_bresp;
         arready_ff <= nxt_arready;
         rvalid_ff <= nxt_rvalid;
         rdata_ff <= nxt_rdata;
         rresp_ff <= nxt_rresp;
      end
   end

   // ---------------- device core ----------------
   always_comb begin
      in_view = (level_ff & live) | (~level_ff & cap_ff);
      flag = |(in_view & ~excl_ff);
      exec = do_wr && wsel[dbio_pkg::RI_INSTR];
      ins = merge12(instr_ff, wdata_ff, wstrb_ff);
      func = ins[2:0];
      hit = exec && (ins[11:9] == dbio_pkg::OPC_IOT) && (ins[8:6] == dbio_pkg::DEV_GROUP)
            && (ins[5:3] == devsel_ff);
      nxt_instr = exec ? ins : instr_ff;
      nxt_hit = exec ? hit : hit_ff;
      nxt_word = word_ff;
      nxt_devsel = devsel_ff;
      nxt_level = level_ff;
      nxt_excl = excl_ff;
      if (do_wr && wsel[dbio_pkg::RI_WORD]) nxt_word = merge12(word_ff, wdata_ff, wstrb_ff);
      if (do_wr && wsel[dbio_pkg::RI_DEVSEL]) nxt_devsel = wdata_ff[2:0];
      if (do_wr && wsel[dbio_pkg::RI_LEVEL]) nxt_level = merge12(level_ff, wdata_ff, wstrb_ff);
      if (do_wr && wsel[dbio_pkg::RI_EXCL]) nxt_excl = merge12(excl_ff, wdata_ff, wstrb_ff);
      nxt_ien = ien_ff;
      nxt_skip = exec ? 1'b0 : skip_ff;
      nxt_dout_n = dout_n_ff;
      clr = 12'h000;
      if (hit) begin
         case (func)
            dbio_pkg::F_IRQ_DIS: nxt_ien = 1'b0;
            dbio_pkg::F_IRQ_EN: nxt_ien = 1'b1;
            dbio_pkg::F_SKIP: nxt_skip = flag;
            dbio_pkg::F_IN_CLR: clr = word_ff;
            dbio_pkg::F_IN_RD: nxt_word = in_view;
            dbio_pkg::F_OUT_CLR: nxt_dout_n = dout_n_ff | word_ff;
            dbio_pkg::F_OUT_SET: nxt_dout_n = dout_n_ff & ~word_ff;
            dbio_pkg::F_OUT_RD: nxt_word = ~dout_n_ff;
            default: nxt_ien = ien_ff;
         endcase
      end
      // capture wins over a clear landing in the same cycle
      nxt_cap = (cap_ff & ~clr) | (fall & ~level_ff);
      // one cycle behind the flag so the pin comes straight from a flop
      nxt_irq = flag & ien_ff;
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         instr_ff <= 12'h000;
         word_ff <= dbio_pkg::WORD_RST;
         cap_ff <= 12'h000;
         dout_n_ff <= ~dbio_pkg::OUT_RST;
         level_ff <= dbio_pkg::LEVEL_RST;
         excl_ff <= dbio_pkg::EXCL_RST;
         devsel_ff <= dbio_pkg::DEV_RST;
         ien_ff <= 1'b0;
         skip_ff <= 1'b0;
         hit_ff <= 1'b0;
         irq_ff <= 1'b0;
      end else begin
         instr_ff <= nxt_instr;
         word_ff <= nxt_word;
         cap_ff <= nxt_cap;
         dout_n_ff <= nxt_dout_n;
         level_ff <= nxt_level;
         excl_ff <= nxt_excl;
         devsel_ff <= nxt_devsel;
         ien_ff <= nxt_ien;
         skip_ff <= nxt_skip;
         hit_ff <= nxt_hit;
         irq_ff <= nxt_irq;
      end
   end

   assign s_axi_awready = awready_ff;
   assign s_axi_wready = wready_ff;
   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp = bresp_ff;
   assign s_axi_arready = arready_ff;
   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rdata = rdata_ff;
   assign s_axi_rresp = rresp_ff;
   assign dout_n = dout_n_ff;
   assign irq_req = irq_ff;

   // ---------------- checks ----------------
   localparam int HOLD_C = dbio_pkg::EDGE_HOLD_CYC;
   logic [2:0] lo0_cnt_ff;
   logic seen0_ff;
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         lo0_cnt_ff <= 3'h0;
         seen0_ff <= 1'b0;
      end else begin
         lo0_cnt_ff <= din_n[0] ? 3'h0 : ((lo0_cnt_ff == 3'h7) ? 3'h7 : lo0_cnt_ff + 3'h1);
         seen0_ff <= din_n[0] ? 1'b0 : (seen0_ff | fall[0]);
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   sequence s_do(logic [2:0] f);
      hit && (func == f);
   endsequence

   sequence s_foreign;
      exec && !hit;
   endsequence

   chk_foreign_ignored: assert property (
      s_foreign |=> $stable(dout_n) && $stable(ien_ff) && !hit_ff)
      else $error("instruction for another device acted on");
   chk_irq_disable: assert property (
      s_do(dbio_pkg::F_IRQ_DIS) |=> !ien_ff ##1 !irq_req)
      else $error("interrupt not disabled");
   chk_irq_raise: assert property (
      s_do(dbio_pkg::F_IRQ_EN) ##1 (flag && ien_ff) |=> irq_req)
      else $error("enabled flag raised no request");
   chk_irq_gate: assert property (
      !(flag && ien_ff) |=> !irq_req)
      else $error("request without enabled flag");
   chk_skip_result: assert property (
      s_do(dbio_pkg::F_SKIP) |=> skip_ff == $past(flag))
      else $error("skip result wrong");
   chk_in_clear: assert property (
      s_do(dbio_pkg::F_IN_CLR) ##0 (fall == 12'h000)
         |=> cap_ff == ($past(cap_ff) & ~$past(word_ff)))
      else $error("selective input clear wrong");
   chk_in_read: assert property (
      s_do(dbio_pkg::F_IN_RD) |=> word_ff == $past(in_view))
      else $error("input read wrong");
   chk_out_clear: assert property (
      s_do(dbio_pkg::F_OUT_CLR) |=> dout_n == ($past(dout_n) | $past(word_ff)))
      else $error("selective output clear wrong");
   chk_out_set: assert property (
      s_do(dbio_pkg::F_OUT_SET) |=> dout_n == ($past(dout_n) & ~$past(word_ff)))
      else $error("selective output set wrong");
   chk_out_read: assert property (
      s_do(dbio_pkg::F_OUT_RD) |=> word_ff == ~$past(dout_n))
      else $error("output readback wrong");
   chk_out_hold: assert property (
      !(hit && (func == dbio_pkg::F_OUT_CLR || func == dbio_pkg::F_OUT_SET)) |=> $stable(dout_n))
      else $error("output changed without set or clear");
   chk_edge_wins: assert property (
      (fall[0] && !level_ff[0]) |=> cap_ff[0] ##1 (cap_ff[0] || $past(clr[0])))
      else $error("captured edge lost");
   chk_edge_sensed: assert property (
      lo0_cnt_ff == 3'(HOLD_C + 4) |-> seen0_ff)
      else $error("held low line not sensed");
   chk_level_live: assert property (
      level_ff[0] && !excl_ff[0] && live[0] |-> in_view[0] && flag)
      else $error("level bit not live");
endmodule

// ==== verification/dbio_field_model.sv ====
`timescale 1ns/100ps
// field-side source: lines rest high through pull-ups, low means one
module dbio_field_model (
   // clock
   input wire logic clk_sys,
   // lines into the unit
   output logic [dbio_pkg::DW-1:0] din_n
);
   initial din_n = 12'hFFF;
   // stretched well past one sample so the input filter cannot drop it
   task automatic pulse(input logic [11:0] m, input int cyc);
      @(posedge clk_sys);
      din_n <= ~m;
      repeat (cyc) @(posedge clk_sys);
      din_n <= 12'hFFF;
   endtask
   task automatic hold(input logic [11:0] m);
      @(posedge clk_sys);
      din_n <= ~m;
   endtask
endmodule

// ==== verification/testbench.sv ====
`timescale 1ns/100ps
module testbench;
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] s_axi_awaddr = 8'h00;
   logic s_axi_awvalid = 1'b0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_bready = 1'b0;
   logic [7:0] s_axi_araddr = 8'h00;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq_req;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic [31:0] s_axi_rdata, rdat;
   logic [11:0] din_n, dout_n;
   logic [2:0] unit = 3'h0;
   int error_cnt = 0;
   int samples_checked = 0;

   always #25 clk_sys = ~clk_sys;

   dbio_top u_dbio_top (.clk_sys(clk_sys), .sys_rst(sys_rst),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .din_n(din_n),
      .dout_n(dout_n), .irq_req(irq_req));

   dbio_field_model u_dbio_field_model (.clk_sys(clk_sys), .din_n(din_n));

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // one write; the bench waits up to 200 cycles for the answer
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      r = 2'h3;
      @(posedge clk_sys);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (n < 200) begin
         @(posedge clk_sys);
         n++;
         if (s_axi_awvalid && s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
            s_axi_wvalid <= 1'b0;
         if (s_axi_bready && s_axi_bvalid) begin
            r = s_axi_bresp;
            s_axi_bready <= 1'b0;
            n = 1000;
         end
      end
      if (n != 1000)
         chk(32'h0, 32'h1);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      r = 2'h3;
      d = 32'h0;
      @(posedge clk_sys);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (n < 200) begin
         @(posedge clk_sys);
         n++;
         if (s_axi_arvalid && s_axi_arready)
            s_axi_arvalid <= 1'b0;
         if (s_axi_rready && s_axi_rvalid) begin
            d = s_axi_rdata;
            r = s_axi_rresp;
            s_axi_rready <= 1'b0;
            n = 1000;
         end
      end
      if (n != 1000)
         chk(32'h0, 32'h1);
   endtask

   task automatic w(input logic [7:0] a, input logic [31:0] d);
      wr(a, d, rsp);
   endtask

   task automatic ins(input logic [2:0] f);
      wr(dbio_pkg::A_INSTR, {20'h0, dbio_pkg::OPC_IOT, dbio_pkg::DEV_GROUP, unit, f}, rsp);
   endtask

   function automatic logic [31:0] word(input logic [11:0] v);
      return {20'h0, v};
   endfunction

   task automatic stat_bit(input int b, output logic v);
      rd(dbio_pkg::A_STAT, rdat, rsp);
      v = rdat[b];
   endtask

   task automatic t_reset;
      rd(dbio_pkg::A_OUTREG, rdat, rsp);
      chk(rsp, dbio_pkg::RESP_OKAY);
      chk(rdat, word(dbio_pkg::OUT_RST));
      chk(word(dout_n), word(12'hFFF));
      rd(dbio_pkg::A_LEVEL, rdat, rsp);
      chk(rdat, 32'h0);
      rd(dbio_pkg::A_EXCL, rdat, rsp);
      chk(rdat, 32'h0);
      rd(dbio_pkg::A_DEVSEL, rdat, rsp);
      chk(rdat, 32'h0);
      $display("reset test done");
   endtask

   task automatic t_output;
      w(dbio_pkg::A_WORD, 32'hA5C);
      chk(rsp, dbio_pkg::RESP_OKAY);
      ins(dbio_pkg::F_OUT_SET);
      chk(word(dout_n), word(~12'hA5C));
      w(dbio_pkg::A_WORD, 32'h00C);
      ins(dbio_pkg::F_OUT_CLR);
      chk(word(dout_n), word(~12'hA50));
      w(dbio_pkg::A_WORD, 32'h0);
      ins(dbio_pkg::F_OUT_RD);
      rd(dbio_pkg::A_WORD, rdat, rsp);
      chk(rdat, 32'hA50);
      ins(dbio_pkg::F_IRQ_EN);
      ins(dbio_pkg::F_IRQ_DIS);
      repeat (20) @(posedge clk_sys);
      chk(word(dout_n), word(~12'hA50));
      $display("output test done");
   endtask

   // bit 0 takes part so the bit-0 edge capture check inside the design (chk_edge_wins) gets exercised
   task automatic t_edge;
      logic v;
      u_dbio_field_model.pulse(12'h009, 3);
      repeat (10) @(posedge clk_sys);
      rd(dbio_pkg::A_INREG, rdat, rsp);
      chk(rdat, 32'h009);
      ins(dbio_pkg::F_SKIP);
      stat_bit(dbio_pkg::ST_SKIP, v);
      chk(v, 1'b1);
      chk(irq_req, 1'b0);
      ins(dbio_pkg::F_IRQ_EN);
      stat_bit(dbio_pkg::ST_IEN, v);
      chk(v, 1'b1);
      repeat (3) @(posedge clk_sys);
      chk(irq_req, 1'b1);
      ins(dbio_pkg::F_IRQ_DIS);
      repeat (3) @(posedge clk_sys);
      chk(irq_req, 1'b0);
      ins(dbio_pkg::F_IN_RD);
      rd(dbio_pkg::A_WORD, rdat, rsp);
      chk(rdat, 32'h009);
      w(dbio_pkg::A_WORD, 32'h004);
      ins(dbio_pkg::F_IN_CLR);
      rd(dbio_pkg::A_INREG, rdat, rsp);
      chk(rdat, 32'h009);
      w(dbio_pkg::A_WORD, 32'h009);
      ins(dbio_pkg::F_IN_CLR);
      rd(dbio_pkg::A_INREG, rdat, rsp);
      chk(rdat, 32'h000);
      ins(dbio_pkg::F_SKIP);
      stat_bit(dbio_pkg::ST_SKIP, v);
      chk(v, 1'b0);
      $display("edge test done");
   endtask

   task automatic t_excl;
      logic v;
      w(dbio_pkg::A_EXCL, 32'h008);
      u_dbio_field_model.pulse(12'h008, 3);
      repeat (10) @(posedge clk_sys);
      ins(dbio_pkg::F_SKIP);
      stat_bit(dbio_pkg::ST_SKIP, v);
      chk(v, 1'b0);
      u_dbio_field_model.pulse(12'h020, 3);
      repeat (10) @(posedge clk_sys);
      ins(dbio_pkg::F_SKIP);
      stat_bit(dbio_pkg::ST_SKIP, v);
      chk(v, 1'b1);
      w(dbio_pkg::A_WORD, 32'hFFF);
      ins(dbio_pkg::F_IN_CLR);
      w(dbio_pkg::A_EXCL, 32'h0);
      $display("exclude test done");
   endtask

   task automatic t_level;
      w(dbio_pkg::A_LEVEL, 32'h011);
      u_dbio_field_model.hold(12'h011);
      repeat (10) @(posedge clk_sys);
      rd(dbio_pkg::A_INREG, rdat, rsp);
      chk(rdat, 32'h011);
      u_dbio_field_model.hold(12'h000);
      repeat (10) @(posedge clk_sys);
      rd(dbio_pkg::A_INREG, rdat, rsp);
      chk(rdat, 32'h000);
      w(dbio_pkg::A_LEVEL, 32'h0);
      $display("level test done");
   endtask

   task automatic t_devsel;
      logic v;
      w(dbio_pkg::A_DEVSEL, 32'h2);
      w(dbio_pkg::A_WORD, 32'h001);
      ins(dbio_pkg::F_OUT_SET);
      chk(word(dout_n), word(~12'hA50));
      stat_bit(dbio_pkg::ST_HIT, v);
      chk(v, 1'b0);
      unit = 3'h2;
      ins(dbio_pkg::F_OUT_SET);
      chk(word(dout_n), word(~12'hA51));
      $display("device select test done");
   endtask

   task automatic t_unmapped;
      wr(8'h40, 32'hFFF, rsp);
      chk(rsp, dbio_pkg::RESP_SLVERR);
      rd(8'h40, rdat, rsp);
      chk(rsp, dbio_pkg::RESP_SLVERR);
      chk(rdat, 32'h0);
      $display("unmapped test done");
   endtask

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // a normal run needs a few hundred cycles
   initial begin
      repeat (20000) @(posedge clk_sys);
      error_cnt++;
      $display("unexpected at %0t: watchdog expired", $time);
      report_and_stop();
   end

   initial begin
      repeat (20) @(posedge clk_sys);
      sys_rst <= 1'b0;
      repeat (2) @(posedge clk_sys);
      t_reset();
      t_output();
      t_edge();
      t_excl();
      t_level();
      t_devsel();
      t_unmapped();
      report_and_stop();
   end
endmodule
